// >>> design/dnvr_consts.svh
// constants of the nonvolatile restore and presence block
`ifndef DNVR_CONSTS_SVH
`define DNVR_CONSTS_SVH

// ************************************************
// address
// ************************************************
`define DNVR_ADDR_UPPER      4'h6
`define DNVR_FIXED_ADDR_HIGH 1'b0
`define DNVR_FIXED_ADDR_MID  1'b0

// ************************************************
// command field of the first data byte
// ************************************************
`define DNVR_CMD_MSB         7
`define DNVR_CMD_LSB         6
`define DNVR_CMD_DAC_ONLY    2'h1
`define DNVR_CMD_DAC_AND_NV  2'h3

// ************************************************
// field layout of stored and returned bytes
// ************************************************
`define DNVR_PD_MSB          5
`define DNVR_PD_LSB          4
`define DNVR_CODE_HI_MSB     3
`define DNVR_CODE_WIDTH      12
`define DNVR_PD_WIDTH        2

// ************************************************
// counts and reset values
// ************************************************
`define DNVR_BIT_LAST        3'h7
`define DNVR_NV_BYTES        2
`define DNVR_NV_RESET_HI     8'h08
`define DNVR_NV_RESET_LO     8'h00

`endif

// >>> design/dnvr_pkg.sv
// types of the nonvolatile restore and presence block
package dnvr_pkg;

    // ************************************************
    // dac register contents
    // ************************************************
    typedef struct packed {
        logic [1:0]  pd;
        logic [11:0] code;
    } dnvr_dac_word_t;

    // ************************************************
    // serial target states
    // ************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_IGNORE
    } dnvr_state_t;

endpackage

// >>> design/dnvr_sync.sv
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps

module dnvr_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire         CLOCK,
    input  wire         RESETN,
    // async in, synced out
    input  wire [W-1:0] d,
    output logic [W-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            // pins idle high, so the chain resets high
            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    meta_q <= 1'b1;
                    q[i]   <= 1'b1;
                end else begin
                    meta_q <= d[i];
                    q[i]   <= meta_q;
                end
            end
        end
    endgenerate

endmodule // dnvr_sync

// >>> design/dnvr_top.sv
// serial target with presence answer, nonvolatile store and power-up restore
// Contract
// R1 - scl and sda are only ever pulled low, released lines return high by pull-ups.
// R2 - a matching address byte is acknowledged by holding sda low in its ninth clock, for read or write.
// R3 - sda is released after the address acknowledge clock so the controller owns the line again; after a read address the code drives the first data bit instead.
// R4 - the controller may probe with an address byte alone and then stop or restart.
// R5 - the controller takes an acknowledge of a read or write address as proof of presence.
// R6 - the lowest address bit is compared against the address-select pin level.
// R7 - a write command with the store code puts the 12-bit code and 2 power-down bits into nonvolatile storage.
// R8 - a read command returns the nonvolatile contents to the controller.
// R9 - after reset the stored contents are copied to the dac register with no command needed.
// R10 - once addressed, each received byte is acknowledged by sda low in the ninth clock.
// R11 - when the controller withholds acknowledge after a read byte, sda is left high for the stop.
// R12 - on an address mismatch sda stays released and the bus is ignored until the next start.
`timescale 1ns/10ps
`include "dnvr_consts.svh"

module dnvr_top (
    // clock and reset
    input  wire                      CLOCK,
    input  wire                      RESETN,
    // serial clock pin
    input  wire                      SCL_I,
    output logic                     SCL_O,
    output logic                     SCL_OE,
    // serial data pin
    input  wire                      SDA_I,
    output logic                     SDA_O,
    output logic                     SDA_OE,
    // address strap
    input  wire                      ADDR_SELECT_PIN,
    // dac register
    output dnvr_pkg::dnvr_dac_word_t DAC_WORD,
    output logic                     NV_RESTORED
);

    // ************************************************
    // pin synchronisers and bus conditions
    // ************************************************
    logic [2:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       sel_s;
    logic       scl_prev_q;
    logic       sda_prev_q;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;

    dnvr_sync #(.W(3)) u_sync (
        .CLOCK  (CLOCK),
        .RESETN (RESETN),
        .d      ({ADDR_SELECT_PIN, SDA_I, SCL_I}),
        .q      (pins_s)
    );

    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];
    assign sel_s = pins_s[2];

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    assign scl_rise   = scl_s & ~scl_prev_q;
    assign scl_fall   = ~scl_s & scl_prev_q;
    assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ************************************************
    // serial state and shifters
    // ************************************************
    dnvr_pkg::dnvr_state_t state_q;
    logic [7:0]            rx_q;
    logic [7:0]            tx_q;
    logic [2:0]            cnt_q;
    logic                  rw_q;
    logic                  master_ack_q;
    logic                  bit_seen_q;
    logic                  sda_oe_q;
    logic                  idx_q;
    logic [7:0]            hold_q;
    logic                  wr_done;
    logic [7:0]            nv_q [0:`DNVR_NV_BYTES-1];
    logic [6:0]            own_addr;
    logic [7:0]            rx_next;

    // strap drives the lowest address bit
    assign own_addr = {`DNVR_ADDR_UPPER, `DNVR_FIXED_ADDR_HIGH, `DNVR_FIXED_ADDR_MID, sel_s}; // R6
    assign rx_next  = {rx_q[6:0], sda_s};
    // second data byte completes a write pair
    assign wr_done  = (state_q == dnvr_pkg::ST_WR_BYTE) && scl_fall && (cnt_q == `DNVR_BIT_LAST) && idx_q;

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            state_q      <= dnvr_pkg::ST_IDLE;
            rx_q         <= 8'h00;
            tx_q         <= 8'h00;
            cnt_q        <= 3'h0;
            rw_q         <= 1'b0;
            master_ack_q <= 1'b0;
            bit_seen_q   <= 1'b0;
            sda_oe_q     <= 1'b0;
            idx_q        <= 1'b0;
        end else if (start_seen) begin
            // start or repeated start wins over everything
            state_q  <= dnvr_pkg::ST_ADDR;
            cnt_q      <= 3'h0;
            sda_oe_q   <= 1'b0;
            idx_q      <= 1'b0;
            bit_seen_q <= 1'b0;
        end else if (stop_seen) begin
            state_q  <= dnvr_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            case (state_q)
                dnvr_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        rx_q       <= rx_next;
                        bit_seen_q <= 1'b1;
                    end
                    // the clock fall that closes a start is no address bit
                    if (scl_fall && bit_seen_q) begin
                        if (cnt_q == `DNVR_BIT_LAST) begin
                            rw_q <= rx_q[0];
                            if (rx_q[7:1] == own_addr) begin
                                sda_oe_q <= 1'b1; // R2
                                state_q  <= dnvr_pkg::ST_ADDR_ACK;
                            end else begin
                                state_q <= dnvr_pkg::ST_IGNORE; // R12
                            end
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                dnvr_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        cnt_q <= 3'h0;
                        if (rw_q) begin
                            // first data bit goes out on the same falling edge
                            tx_q     <= nv_q[idx_q]; // R8
                            sda_oe_q <= ~nv_q[idx_q][7];
                            state_q  <= dnvr_pkg::ST_RD_BYTE;
                        end else begin
                            sda_oe_q <= 1'b0; // R3
                            state_q  <= dnvr_pkg::ST_WR_BYTE;
                        end
                    end
                end
                dnvr_pkg::ST_WR_BYTE: begin
                    if (scl_rise) begin
                        rx_q <= rx_next;
                    end
                    if (scl_fall) begin
                        if (cnt_q == `DNVR_BIT_LAST) begin
                            sda_oe_q <= 1'b1; // R10
                            state_q  <= dnvr_pkg::ST_WR_ACK;
                            idx_q    <= ~idx_q;
                        end else begin
                            cnt_q <= cnt_q + 3'h1;
                        end
                    end
                end
                dnvr_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        cnt_q    <= 3'h0;
                        state_q  <= dnvr_pkg::ST_WR_BYTE;
                    end
                end
                dnvr_pkg::ST_RD_BYTE: begin
                    if (scl_fall) begin
                        if (cnt_q == `DNVR_BIT_LAST) begin
                            sda_oe_q <= 1'b0;
                            idx_q    <= ~idx_q;
                            state_q  <= dnvr_pkg::ST_RD_ACK;
                        end else begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                            cnt_q    <= cnt_q + 3'h1;
                        end
                    end
                end
                dnvr_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        master_ack_q <= ~sda_s;
                    end
                    if (scl_fall) begin
                        cnt_q <= 3'h0;
                        if (master_ack_q) begin
                            tx_q     <= nv_q[idx_q];
                            sda_oe_q <= ~nv_q[idx_q][7];
                            state_q  <= dnvr_pkg::ST_RD_BYTE;
                        end else begin
                            sda_oe_q <= 1'b0; // R11
                            state_q  <= dnvr_pkg::ST_IGNORE;
                        end
                    end
                end
                default: begin
                    // idle and ignore wait for a start with sda released
                    sda_oe_q <= 1'b0; // R12
                end
            endcase
        end
    end

    // ************************************************
    // first write byte held until its pair completes
    // ************************************************
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            hold_q <= 8'h00;
        end else if ((state_q == dnvr_pkg::ST_WR_BYTE) && scl_fall && (cnt_q == `DNVR_BIT_LAST) && !idx_q) begin
            hold_q <= rx_q;
        end
    end

    // ************************************************
    // nonvolatile storage, one byte per index
    // ************************************************
    // storage resets only with RESETN; in silicon it would keep its cells
    genvar gi;
    generate
        for (gi = 0; gi < `DNVR_NV_BYTES; gi++) begin : g_nv
            always_ff @(posedge CLOCK or negedge RESETN) begin
                if (!RESETN) begin
                    nv_q[gi] <= (gi == 0) ? `DNVR_NV_RESET_HI : `DNVR_NV_RESET_LO;
                end else if (wr_done && (hold_q[`DNVR_CMD_MSB:`DNVR_CMD_LSB] == `DNVR_CMD_DAC_AND_NV)) begin
                    // command bits are not stored, they read back as zero
                    nv_q[gi] <= (gi == 0) ? {2'b00, hold_q[`DNVR_PD_MSB:0]} : rx_q; // R7
                end
            end
        end
    endgenerate

    // ************************************************
    // dac register and power-up restore
    // ************************************************
    dnvr_pkg::dnvr_dac_word_t dac_q;
    logic                     restored_q;
    logic                     cmd_valid;

    assign cmd_valid = (hold_q[`DNVR_CMD_MSB:`DNVR_CMD_LSB] == `DNVR_CMD_DAC_ONLY) ||
                       (hold_q[`DNVR_CMD_MSB:`DNVR_CMD_LSB] == `DNVR_CMD_DAC_AND_NV);

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            dac_q      <= '0;
            restored_q <= 1'b0;
        end else if (!restored_q) begin
            // first edge after release copies storage into the dac
            dac_q.pd   <= nv_q[0][`DNVR_PD_MSB:`DNVR_PD_LSB]; // R9
            dac_q.code <= {nv_q[0][`DNVR_CODE_HI_MSB:0], nv_q[1]}; // R9
            restored_q <= 1'b1;
        end else if (wr_done && cmd_valid) begin
            dac_q.pd   <= hold_q[`DNVR_PD_MSB:`DNVR_PD_LSB];
            dac_q.code <= {hold_q[`DNVR_CODE_HI_MSB:0], rx_q};
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    logic scl_o_q;
    logic sda_o_q;

    // open-drain: the data value is always low, only the enable moves
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            scl_o_q <= 1'b0; // R1
            sda_o_q <= 1'b0; // R1
        end else begin
            scl_o_q <= 1'b0;
            sda_o_q <= 1'b0;
        end
    end

    // no clock stretching, so scl enable is a held-low flop
    logic scl_oe_q;
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            scl_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= 1'b0;
        end
    end

    assign SCL_O       = scl_o_q;
    assign SCL_OE      = scl_oe_q;
    assign SDA_O       = sda_o_q;
    assign SDA_OE      = sda_oe_q;
    assign DAC_WORD    = dac_q;
    assign NV_RESTORED = restored_q;

endmodule // dnvr_top

// >>> test/dnvr_checker.sv
// pin-level checks of the serial target with presence answer and restore
`timescale 1ns/10ps
`include "dnvr_consts.svh"

module dnvr_checker (
    // clock and reset
    input wire                      CLOCK,
    input wire                      RESETN,
    // serial pins
    input wire                      SCL_I,
    input logic                     SCL_O,
    input logic                     SCL_OE,
    input wire                      SDA_I,
    input logic                     SDA_O,
    input logic                     SDA_OE,
    // strap and dac register
    input wire                      ADDR_SELECT_PIN,
    input dnvr_pkg::dnvr_dac_word_t DAC_WORD,
    input logic                     NV_RESTORED
);
    // ********
    // bus tracking on raw pin levels
    // ********
    logic       scl_q;
    logic       sda_q;
    logic       ign;
    logic       nacked;
    logic [3:0] bitcnt;
    logic [7:0] bytecnt;
    logic [7:0] shreg;
    logic [7:0] addr;
    logic [6:0] own;
    logic       hit_now;
    logic       hit;

    assign own     = {`DNVR_ADDR_UPPER, `DNVR_FIXED_ADDR_HIGH, `DNVR_FIXED_ADDR_MID, ADDR_SELECT_PIN};
    assign hit_now = (shreg[7:1] == own);
    assign hit     = (addr[7:1] == own);

    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= SCL_I;
            sda_q <= SDA_I;
        end
    end

    // bitcnt counts rises of the byte; the ninth rise closes it
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            bitcnt  <= 4'h0;
            bytecnt <= 8'h00;
            shreg   <= 8'h00;
            addr    <= 8'h00;
            ign     <= 1'b0;
            nacked  <= 1'b0;
        end else if (SCL_I && scl_q && sda_q && !SDA_I) begin
            bitcnt  <= 4'h0;
            bytecnt <= 8'h00;
            ign     <= 1'b0;
            nacked  <= 1'b0;
        end else if (SCL_I && !scl_q) begin
            bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
            if (bitcnt != 4'h8) begin
                shreg <= {shreg[6:0], SDA_I};
            end else begin
                bytecnt <= bytecnt + 8'h01;
                if (bytecnt == 8'h00) begin
                    addr <= shreg;
                    ign  <= !hit_now;
                end else if (addr[0] && SDA_I) begin
                    nacked <= 1'b1;
                end
            end
        end
    end

    // ********
    // assertions
    // ********
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    AST_SCL_NEVER_PULLED: assert property (!SCL_OE && !SCL_O) else $error("clock pin driven");
    AST_SDA_ONLY_LOW: assert property (!SDA_O) else $error("data pin driven high");
    AST_ACK_MATCH: assert property ($rose(SCL_I) && bitcnt == 4'h8 && bytecnt == 8'h00 && hit_now |-> SDA_OE)
        else $error("own address not acknowledged");
    AST_NO_ACK_MISMATCH: assert property ($rose(SCL_I) && bitcnt == 4'h8 && bytecnt == 8'h00 && !hit_now |-> !SDA_OE)
        else $error("foreign address acknowledged");
    AST_IGNORED_QUIET: assert property (ign |-> !SDA_OE) else $error("data driven while ignoring");
    AST_ADDR_RELEASE: assert property ($rose(SCL_I) && bitcnt == 4'h0 && bytecnt == 8'h01 && !addr[0] |-> !SDA_OE)
        else $error("data held after address ack");
    AST_DATA_ACK: assert property ($rose(SCL_I) && bitcnt == 4'h8 && bytecnt != 8'h00 && !addr[0] && hit |-> SDA_OE)
        else $error("write byte not acknowledged");
    AST_NACK_RELEASE: assert property (nacked |-> !SDA_OE) else $error("data driven after nack");
    AST_SDA_STABLE_HIGH: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE))
        else $error("data changed while clock high");
    AST_RESTORE: assert property (!NV_RESTORED |=> NV_RESTORED && DAC_WORD == 14'h0800)
        else $error("restore missing");
    AST_DAC_ON_PAIR: assert property ($changed(DAC_WORD) && $past(NV_RESTORED) |->
        bitcnt == 4'h8 && !bytecnt[0] && bytecnt != 8'h00 && !addr[0])
        else $error("dac changed outside a byte pair");

    cover property ($rose(SCL_I) && bitcnt == 4'h8 && bytecnt == 8'h00 && hit_now);
    cover property (nacked);
    cover property ($changed(DAC_WORD) && $past(NV_RESTORED));
endmodule // dnvr_checker

bind dnvr_top dnvr_checker dnvr_checker_inst (
    .CLOCK(CLOCK), .RESETN(RESETN), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE), .SDA_I(SDA_I),
    .SDA_O(SDA_O), .SDA_OE(SDA_OE), .ADDR_SELECT_PIN(ADDR_SELECT_PIN), .DAC_WORD(DAC_WORD),
    .NV_RESTORED(NV_RESTORED)
);

// >>> test/dnvr_master_model.sv
// bus controller model driving the serial pins through pull-down enables
`timescale 1ns/10ps

module dnvr_master_model (
    // clock
    input  wire  clk,
    // wired data level
    input  wire  sda,
    // high while pulling the line low
    output logic scl_oe,
    output logic sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // also a repeated start; the target must have let go of data first
    task automatic start_cond();
        tick(2);
        sda_oe = 1'b0;
        tick(3);
        scl_oe = 1'b0;
        tick(3);
        sda_oe = 1'b1;
        tick(3);
        scl_oe = 1'b1;
    endtask

    task automatic stop_cond();
        tick(2);
        sda_oe = 1'b1;
        tick(3);
        scl_oe = 1'b0;
        tick(3);
        sda_oe = 1'b0;
        tick(4);
    endtask

    // 5 clocks low, 3 high; data moves only while the clock is low
    task automatic bit_cycle(input logic b, output logic r);
        tick(2);
        sda_oe = ~b;
        tick(3);
        scl_oe = 1'b0;
        tick(2);
        r = sda;
        tick(1);
        scl_oe = 1'b1;
    endtask

    // ninth bit: ack_out high leaves the line to the target
    task automatic xfer(input logic [7:0] b, input logic ack_out, output logic [7:0] r, output logic ack_in);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], r[i]);
        end
        bit_cycle(ack_out, ack_in);
    endtask
endmodule // dnvr_master_model

// >>> test/test_dac_nv_restore_i2c_presence.sv
// testbench of the serial target with presence answer and nonvolatile restore
`timescale 1ns/10ps
`include "dnvr_consts.svh"

module test_dac_nv_restore_i2c_presence;
    // ********
    // signals; released lines float high through pull-ups
    // ********
    logic                     clock;
    logic                     resetn;
    logic                     addr_sel;
    logic                     scl_oe;
    logic                     sda_oe;
    logic                     m_scl_oe;
    logic                     m_sda_oe;
    logic                     nv_restored;
    logic                     ack;
    logic [7:0]               rd;
    dnvr_pkg::dnvr_dac_word_t dac_word;
    int                       n_fail = 0;
    int                       cmp_count = 0;
    wire                      scl_w = ~(m_scl_oe | scl_oe);
    wire                      sda_w = ~(m_sda_oe | sda_oe);
    wire [6:0]                dev = {`DNVR_ADDR_UPPER, `DNVR_FIXED_ADDR_HIGH, `DNVR_FIXED_ADDR_MID, 1'b0};

    dnvr_top dnvr_top_inst (
        .CLOCK(clock), .RESETN(resetn), .SCL_I(scl_w), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda_w), .SDA_O(),
        .SDA_OE(sda_oe), .ADDR_SELECT_PIN(addr_sel), .DAC_WORD(dac_word), .NV_RESTORED(nv_restored)
    );
    dnvr_master_model dnvr_master_model_inst (.clk(clock), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ********
    // helpers
    // ********
    task automatic finish_test();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic a);
        dnvr_master_model_inst.xfer(b, a, rd, ack);
    endtask

    // last read byte: nack, then the line must stay free for the stop
    task automatic read_last(input logic [7:0] exp);
        put(8'hff, 1'b1);
        check(rd, exp);
        repeat (4) @(negedge clock);
        check(sda_w, 1'b1);
        dnvr_master_model_inst.stop_cond();
    endtask

    // ********
    // scenarios
    // ********
    task automatic t_restore(input logic [13:0] exp);
        check(dac_word, exp);
        check(nv_restored, 1'b1);
    endtask

    task automatic t_probe();
        dnvr_master_model_inst.start_cond();
        put({dev, 1'b0}, 1'b1);
        check(ack, 1'b0);
        dnvr_master_model_inst.start_cond();
        put({dev, 1'b1}, 1'b1);
        check(ack, 1'b0);
        read_last(`DNVR_NV_RESET_HI);
    endtask

    task automatic t_mismatch();
        dnvr_master_model_inst.start_cond();
        put({dev[6:1], 1'b1, 1'b0}, 1'b1);
        check(ack, 1'b1);
        put(8'hc5, 1'b1);
        check(ack, 1'b1);
        dnvr_master_model_inst.stop_cond();
        addr_sel = 1'b1;
        dnvr_master_model_inst.start_cond();
        put({dev[6:1], 1'b1, 1'b0}, 1'b1);
        check(ack, 1'b0);
        dnvr_master_model_inst.start_cond();
        put({dev, 1'b0}, 1'b1);
        check(ack, 1'b1);
        dnvr_master_model_inst.stop_cond();
        addr_sel = 1'b0;
    endtask

    task automatic t_write(input logic [1:0] cmd, input logic [13:0] w, input logic [13:0] e_dac,
                           input logic [13:0] e_nv);
        dnvr_master_model_inst.start_cond();
        put({dev, 1'b0}, 1'b1);
        check(ack, 1'b0);
        put({cmd, w[13:8]}, 1'b1);
        check(ack, 1'b0);
        put(w[7:0], 1'b1);
        check(ack, 1'b0);
        dnvr_master_model_inst.stop_cond();
        check(dac_word, e_dac);
        dnvr_master_model_inst.start_cond();
        put({dev, 1'b1}, 1'b1);
        put(8'hff, 1'b0);
        check(rd, {2'b00, e_nv[13:8]});
        put(8'hff, 1'b0);
        check(rd, e_nv[7:0]);
        read_last({2'b00, e_nv[13:8]});
    endtask

    // ********
    // main sequence and hang guard
    // ********
    initial begin
        resetn   = 1'b0;
        addr_sel = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        t_restore(14'h0800);
        t_probe();
        t_mismatch();
        t_write(`DNVR_CMD_DAC_ONLY, 14'h25a3, 14'h25a3, 14'h0800);
        t_write(`DNVR_CMD_DAC_AND_NV, 14'h13c7, 14'h13c7, 14'h13c7);
        t_write(2'h0, 14'h3fff, 14'h13c7, 14'h13c7);
        resetn = 1'b0;
        repeat (3) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        t_restore(14'h0800);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        finish_test();
    end
endmodule // test_dac_nv_restore_i2c_presence
